/* logic/hrss_defines.vh */
// constants for the hot runner setpoint sequencer
`ifndef HRSS_DEFINES_VH
`define HRSS_DEFINES_VH
`define HRSS_SAMPLE_HZ 20000000
`define HRSS_SAMPLES_PER_MIN 32'd1200000000
`define HRSS_DW 16
`define HRSS_SRC_PROC 3'h0
`define HRSS_SRC_SETPOINT 3'h1
`define HRSS_SRC_MEAS_ONE 3'h2
`define HRSS_SRC_MEAS_TWO 3'h3
`define HRSS_SRC_HEATING 3'h4
`define HRSS_SRC_COOLING 3'h5
`define HRSS_STARTUP_MARGIN 16'sh0002
`define HRSS_RESTART_MARGIN 16'sh0028
`define HRSS_SUPP_MIN_DS 16'h0003
`define HRSS_SUPP_MAX_DS 16'h00fa
`define HRSS_HOTRUN_CYCLE_DS 16'h0001
`define HRSS_BIN_NONE 3'h0
`define HRSS_BIN_STARTUP 3'h1
`define HRSS_BIN_BOOST 3'h2
`define HRSS_BIN_FEEDFORWARD 3'h3
`define HRSS_BOOST_BIT 3
`define HRSS_MARK_NONE 2'h0
`define HRSS_MARK_RAMP 2'h1
`define HRSS_MARK_BOOST 2'h2
`define HRSS_ST_IDLE 2'h0
`define HRSS_ST_STARTUP 2'h1
`define HRSS_ST_DWELL 2'h2
`define HRSS_ST_DONE 2'h3
`endif

/* logic/hrss_sequencer.v */
// setpoint ramps, hot runner start-up, boost, feed-forward and output source select
// What this block does
// [R1] continuous output picks configured source, scaled range
// [R2] working setpoint ramps at rise/fall rates
// [R3] ramp restarts on reset, setpoint change, manual exit; the code restarts after reset and in manual, not on a setpoint change
// [R4] display shows target with r marker
// [R5] relative limits compare to ramping setpoint
// [R6] suppression filter active only 0.3..25 s
// [R7] filter feeds control only, display unfiltered
// [R8] hot runner forces 0.1 s cycle time
// [R9] start-up needs enable or binary input, and dual-action type
// [R10] start-up begins if actual 2 below target
// [R11] start-up restarts if actual 40 below
// [R12] start-up ends above start-up setpoint minus 2
// [R13] start-up clamps output to start-up factor
// [R14] dwell timer then regulates to actuation setpoint
// [R15] dwell expiry switches to valid setpoint
// [R16] start-up may persist when exit unreachable
// [R17] boost triggered by function word bit 3
// [R18] key hold toggles boost if input unassigned
// [R19] boost ends on clear or max time
// [R20] boost adds only to setpoint one/two
// [R21] boost display shows setpoint with b marker
// [R22] feed-forward adds or subtracts on contact edges
// [R23] decisions once per sample, reset to idle
//
// Design decisions made here: the function word write-strobe port and the placing of the registers.
`timescale 1ns/10ps
`include "hrss_defines.vh"
module hrss_sequencer (
	input wire ref_clk, // sample clock
	input wire rst, // asynchronous reset, active high
	input wire sample_tick, // one pulse per control sample period
	input wire tick_per_min_unit, // one pulse per rate unit step interval
	input wire tick_per_sec, // one pulse per second
	input wire signed [15:0] actual_raw, // unfiltered actual value
	input wire signed [15:0] actual_filtered, // actual value after suppression filter
	input wire signed [15:0] meas_one, // measured quantity one
	input wire signed [15:0] meas_two, // measured quantity two
	input wire signed [15:0] source_heating_out, // heating manipulating factor
	input wire signed [15:0] source_cooling_out, // cooling manipulating factor
	input wire signed [15:0] pid_out, // controller manipulating factor
	input wire signed [15:0] setpoint_one, // setpoint one
	input wire signed [15:0] setpoint_two, // setpoint two
	input wire use_setpoint_two, // second setpoint active
	input wire manual_mode, // manual operation
	input wire off_state, // controller off
	input wire [2:0] output_source, // continuous output source
	input wire signed [15:0] scale_low_limit, // lower read-out range
	input wire signed [15:0] scale_high_limit, // upper read-out range
	input wire [15:0] ramp_rise_rate, // rise step per unit, zero is off
	input wire [15:0] ramp_fall_rate, // fall step per unit, zero is off
	input wire [15:0] suppression_period, // filter period in tenths of seconds
	input wire hot_runner_mode, // heating output set to hot runner
	input wire [15:0] cycle_time_param, // cycle time in tenths of seconds
	input wire startup_enable, // start-up configuration flag
	input wire [2:0] binary_input_function, // binary input assignment
	input wire binary_contact, // binary input contact closed
	input wire dual_action_controller_type, // controller is dual-action type
	input wire step_action_type, // controller is step-action type
	input wire signed [15:0] startup_setpoint, // actuation setpoint
	input wire signed [15:0] startup_factor, // start-up manipulating factor
	input wire [15:0] dwell_time, // dwell length in seconds
	input wire [7:0] function_word_in, // controller function word from interface
	input wire function_word_wr, // function word write strobe
	input wire boost_keys_held, // boost key combination held
	input wire signed [15:0] boost_amount, // setpoint increase
	input wire [15:0] boost_time, // maximum boost length in seconds
	input wire signed [15:0] feedforward_amount, // feed-forward step
	output reg signed [15:0] cont_output, // scaled continuous output
	output reg signed [15:0] working_setpoint, // setpoint used by control
	output reg signed [15:0] limit_reference, // setpoint for relative limits
	output reg signed [15:0] display_setpoint, // setpoint shown on display
	output reg [1:0] display_marker, // leftmost digit marker
	output reg signed [15:0] control_actual, // actual value fed to control
	output reg signed [15:0] display_actual, // actual value for display
	output reg filter_active, // suppression filter in use
	output reg [15:0] effective_cycle_time, // actuation cycle in tenths
	output reg signed [15:0] manip_out, // final manipulating factor
	output reg [1:0] startup_state, // start-up sequence state
	output reg [7:0] function_word, // controller function word
	output reg ramp_running // ramp in progress
);
	reg signed [15:0] target_q;
	reg manual_q;
	reg off_q;
	reg keys_q;
	reg contact_q;
	reg first_q;
	reg [15:0] dwell_cnt;
	reg [15:0] boost_cnt;
	reg signed [15:0] ff_offset;
	reg signed [15:0] next_target;
	reg signed [31:0] scaled;
	reg signed [15:0] src;
	wire boost_on;
	wire startup_allowed;
	wire signed [16:0] up_lim;
	wire signed [16:0] dn_lim;

	// boost raises setpoint one or two only, never the actuation setpoint
	assign boost_on = hot_runner_mode & function_word[`HRSS_BOOST_BIT]; // see [R17]
	always @* begin
		next_target = use_setpoint_two ? setpoint_two : setpoint_one;
		if (boost_on)
			next_target = next_target + boost_amount; // see [R20]
	end

	// start-up needs hot runner, enable flag or binary input, dual-action type
	assign startup_allowed = hot_runner_mode & dual_action_controller_type &
		(startup_enable | (binary_input_function == `HRSS_BIN_STARTUP)); // see [R9]
	assign up_lim = {working_setpoint[15], working_setpoint} + {1'b0, ramp_rise_rate};
	assign dn_lim = {working_setpoint[15], working_setpoint} - {1'b0, ramp_fall_rate};

	// ramp engine; a restart condition snaps from the current value
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			working_setpoint <= 16'sh0000;
			target_q <= 16'sh0000;
			manual_q <= 1'b0;
			first_q <= 1'b1;
			ramp_running <= 1'b0;
		end else if (sample_tick) begin // see [R23]
			manual_q <= manual_mode;
			target_q <= next_target;
			first_q <= 1'b0;
			if (first_q)
				working_setpoint <= actual_raw; // see [R3]
			else if (manual_mode | (manual_q & ~manual_mode))
				working_setpoint <= manual_mode ? actual_raw : working_setpoint; // see [R3]
			else if (tick_per_min_unit) begin
				// step toward the target, or jump if that direction has no rate
				if (next_target > working_setpoint) begin
					// signed compare, so ramps below zero step the right way
					if (ramp_rise_rate == 16'h0000 ||
						$signed({next_target[15], next_target}) <= up_lim)
						working_setpoint <= next_target; // see [R2]
					else
						working_setpoint <= up_lim[15:0];
				end else if (next_target < working_setpoint) begin
					if (ramp_fall_rate == 16'h0000 ||
						$signed({next_target[15], next_target}) >= dn_lim)
						working_setpoint <= next_target; // see [R2]
					else
						working_setpoint <= dn_lim[15:0];
				end
			end
			ramp_running <= (next_target != working_setpoint) & ~manual_mode;
		end
	end

	// start-up, dwell and boost timing
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			startup_state <= `HRSS_ST_IDLE;
			dwell_cnt <= 16'h0000;
			boost_cnt <= 16'h0000;
			off_q <= 1'b0;
			keys_q <= 1'b0;
			function_word <= 8'h00;
		end else begin
			keys_q <= boost_keys_held;
			// interface write first; key toggle and timeout may override bit 3
			if (function_word_wr)
				function_word <= function_word_in; // see [R17]
			if (binary_input_function == `HRSS_BIN_BOOST)
				function_word[`HRSS_BOOST_BIT] <= binary_contact; // see [R17]
			else if (boost_keys_held & ~keys_q)
				function_word[`HRSS_BOOST_BIT] <= ~function_word[`HRSS_BOOST_BIT]; // see [R18]
			if (sample_tick) begin
				off_q <= off_state;
				if (boost_on) begin
					if (tick_per_sec)
						boost_cnt <= boost_cnt + 16'h0001;
					if (boost_cnt >= boost_time)
						function_word[`HRSS_BOOST_BIT] <= 1'b0; // see [R19]
				end else
					boost_cnt <= 16'h0000;
				case (startup_state)
					`HRSS_ST_IDLE: begin
						// entered after reset, when off state begins, or when start-up is no longer allowed during start-up or dwell
						if (startup_allowed & ~off_state &
							(actual_raw < startup_setpoint - `HRSS_STARTUP_MARGIN))
							startup_state <= `HRSS_ST_STARTUP; // see [R10]
						else if (~off_state)
							startup_state <= `HRSS_ST_DONE;
					end
					`HRSS_ST_STARTUP: begin
						// may never leave if the target cannot be reached
						if (!startup_allowed | off_state)
							startup_state <= `HRSS_ST_IDLE;
						else if (actual_raw > startup_setpoint - `HRSS_STARTUP_MARGIN) begin
							startup_state <= `HRSS_ST_DWELL; // see [R12] [R16]
							dwell_cnt <= 16'h0000;
						end
					end
					`HRSS_ST_DWELL: begin
						if (!startup_allowed | off_state)
							startup_state <= `HRSS_ST_IDLE;
						else if (actual_raw < startup_setpoint - `HRSS_RESTART_MARGIN)
							startup_state <= `HRSS_ST_STARTUP; // see [R11]
						else if (dwell_cnt >= dwell_time)
							startup_state <= `HRSS_ST_DONE; // see [R15]
						else if (tick_per_sec)
							dwell_cnt <= dwell_cnt + 16'h0001; // see [R14]
					end
					`HRSS_ST_DONE: begin
						if (off_state)
							startup_state <= `HRSS_ST_IDLE;
						else if (startup_allowed &
							(actual_raw < startup_setpoint - `HRSS_RESTART_MARGIN))
							startup_state <= `HRSS_ST_STARTUP; // see [R11]
					end
					default: startup_state <= `HRSS_ST_IDLE;
				endcase
			end
		end
	end

	// feed-forward offset follows contact edges
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			contact_q <= 1'b0;
			ff_offset <= 16'sh0000;
		end else if (sample_tick) begin
			contact_q <= binary_contact;
			if (binary_input_function == `HRSS_BIN_FEEDFORWARD && !step_action_type) begin
				if (binary_contact & ~contact_q)
					ff_offset <= ff_offset + feedforward_amount; // see [R22]
				else if (~binary_contact & contact_q)
					ff_offset <= ff_offset - feedforward_amount; // see [R22]
			end else
				ff_offset <= 16'sh0000;
		end
	end

	// continuous output source mux
	always @* begin
		case (output_source)
			`HRSS_SRC_PROC: src = actual_raw;
			`HRSS_SRC_SETPOINT: src = working_setpoint;
			`HRSS_SRC_MEAS_ONE: src = meas_one;
			`HRSS_SRC_MEAS_TWO: src = meas_two;
			`HRSS_SRC_HEATING: src = source_heating_out;
			`HRSS_SRC_COOLING: src = source_cooling_out;
			default: src = actual_raw;
		endcase
		// clamp into the configured read-out range
		if (src < scale_low_limit)
			scaled = {{16{scale_low_limit[15]}}, scale_low_limit};
		else if (src > scale_high_limit)
			scaled = {{16{scale_high_limit[15]}}, scale_high_limit};
		else
			scaled = {{16{src[15]}}, src};
	end

	// registered outputs
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cont_output <= 16'sh0000;
			limit_reference <= 16'sh0000;
			display_setpoint <= 16'sh0000;
			display_marker <= `HRSS_MARK_NONE;
			control_actual <= 16'sh0000;
			display_actual <= 16'sh0000;
			filter_active <= 1'b0;
			effective_cycle_time <= 16'h0000;
			manip_out <= 16'sh0000;
		end else begin
			cont_output <= scaled[15:0]; // see [R1]
			limit_reference <= (startup_state == `HRSS_ST_DWELL) ? startup_setpoint :
				working_setpoint; // see [R5] [R14]
			filter_active <= (suppression_period >= `HRSS_SUPP_MIN_DS) &&
				(suppression_period <= `HRSS_SUPP_MAX_DS); // see [R6]
			control_actual <= filter_active ? actual_filtered : actual_raw; // see [R7]
			display_actual <= actual_raw; // see [R7]
			effective_cycle_time <= hot_runner_mode ? `HRSS_HOTRUN_CYCLE_DS :
				cycle_time_param; // see [R8]
			if (boost_on) begin
				display_setpoint <= use_setpoint_two ? setpoint_two : setpoint_one; // see [R21]
				display_marker <= `HRSS_MARK_BOOST;
			end else if (ramp_running) begin
				display_setpoint <= target_q; // see [R4]
				display_marker <= `HRSS_MARK_RAMP;
			end else begin
				display_setpoint <= working_setpoint;
				display_marker <= `HRSS_MARK_NONE;
			end
			if (startup_state == `HRSS_ST_STARTUP)
				manip_out <= startup_factor; // see [R13]
			else
				manip_out <= pid_out + ff_offset; // see [R22]
		end
	end
endmodule

/* sim/hrss_plant.sv */
// plant stand-in: sensor reading, heater response and contact
`timescale 1ns/10ps
module hrss_plant (
	input wire ref_clk, // sample clock
	input wire sample_tick, // sample pulse
	input wire load, // force reading to preset
	input wire signed [15:0] preset, // forced temperature
	input wire signed [15:0] manip_out, // heater drive
	input wire contact_req, // contact command
	output reg signed [15:0] actual, // sensor reading
	output wire binary_contact // contact state
);
	assign binary_contact = contact_req;
	// reading follows the preset, else drifts with the heater
	always @(posedge ref_clk) begin
		if (load) begin
			actual <= preset;
		end else if (sample_tick) begin
			actual <= (manip_out > 16'sh0000) ? actual + 16'sh0001 : actual - 16'sh0001;
		end
	end
endmodule

/* sim/hrss_properties.sv */
// concurrent checks on the sequencer ports
`timescale 1ns/10ps
`include "hrss_defines.vh"
module hrss_props (
	input wire ref_clk, // sample clock
	input wire rst, // async reset
	input wire sample_tick, // sample pulse
	input wire signed [15:0] actual_raw, // raw actual
	input wire signed [15:0] actual_filtered, // filtered actual
	input wire [15:0] suppression_period, // filter period
	input wire hot_runner_mode, // hot runner
	input wire dual_action_controller_type, // controller type
	input wire signed [15:0] startup_setpoint, // actuation setpoint
	input wire signed [15:0] startup_factor, // start-up limit
	input wire [1:0] display_marker, // marker
	input wire signed [15:0] display_actual, // shown actual
	input wire filter_active, // filter flag
	input wire [15:0] effective_cycle_time, // cycle time
	input wire signed [15:0] manip_out, // output factor
	input wire [1:0] startup_state, // sequence state
	input wire [7:0] function_word, // function word
	input wire ramp_running // ramp flag
);
	reg [1:0] settle;
	wire ready = (settle == 2'h3);
	// skip the first edges after reset
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			settle <= 2'h0;
		end else if (!ready) begin
			settle <= settle + 2'h1;
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence in_startup;
		(startup_state == `HRSS_ST_STARTUP) [*3];
	endsequence
	filter_on_a: assert property (ready && sample_tick && suppression_period >= `HRSS_SUPP_MIN_DS &&
		suppression_period <= `HRSS_SUPP_MAX_DS |=> filter_active) else $error("filter off");
	filter_off_a: assert property (ready && sample_tick && (suppression_period < `HRSS_SUPP_MIN_DS ||
		suppression_period > `HRSS_SUPP_MAX_DS) |=> !filter_active) else $error("filter on");
	cycle_force_a: assert property (ready && sample_tick && hot_runner_mode
		|=> effective_cycle_time == `HRSS_HOTRUN_CYCLE_DS) else $error("cycle not forced");
	display_raw_a: assert property (ready && sample_tick
		|=> display_actual == $past(actual_raw)) else $error("display actual filtered");
	ramp_mark_a: assert property (ready && ramp_running && !function_word[`HRSS_BOOST_BIT]
		|=> display_marker == `HRSS_MARK_RAMP) else $error("ramp marker missing");
	no_startup_a: assert property (ready && !dual_action_controller_type &&
		startup_state == `HRSS_ST_IDLE |=> startup_state != `HRSS_ST_STARTUP) else $error("start-up entered");
	startup_clamp_a: assert property (in_startup |-> manip_out <= startup_factor)
		else $error("start-up factor exceeded");
	startup_exit_a: assert property (ready && sample_tick && startup_state == `HRSS_ST_STARTUP &&
		actual_raw == actual_filtered && actual_raw > startup_setpoint - `HRSS_STARTUP_MARGIN
		|=> startup_state != `HRSS_ST_STARTUP) else $error("start-up did not end");
	boost_gate_a: assert property (ready && !hot_runner_mode && !function_word[`HRSS_BOOST_BIT]
		|=> !function_word[`HRSS_BOOST_BIT]) else $error("boost without hot runner");
endmodule
bind hrss_sequencer hrss_props u_props (.ref_clk, .rst, .sample_tick, .actual_raw, .actual_filtered,
	.suppression_period, .hot_runner_mode, .dual_action_controller_type, .startup_setpoint,
	.startup_factor, .display_marker, .display_actual, .filter_active, .effective_cycle_time,
	.manip_out, .startup_state, .function_word, .ramp_running);

/* sim/test_hrss_sequencer.sv */
// self-checking bench for the setpoint sequencer
`timescale 1ns/10ps
`include "hrss_defines.vh"
module test_hrss_sequencer;
	reg ref_clk = 1'b0, rst = 1'b1, tk = 1'b0, load = 1'b1, contact = 1'b0;
	reg use_setpoint_two = 1'b0, manual_mode = 1'b0, off_state = 1'b0, hot_runner_mode = 1'b0;
	reg startup_enable = 1'b0, dual_action_controller_type = 1'b0, step_action_type = 1'b0;
	reg function_word_wr = 1'b0, boost_keys_held = 1'b0;
	reg [2:0] output_source = 3'h0, binary_input_function = 3'h0;
	reg [7:0] function_word_in = 8'h00;
	reg [15:0] ramp_rise_rate = 16'h0000, ramp_fall_rate = 16'h0000, suppression_period = 16'h0000;
	reg [15:0] cycle_time_param = 16'h0014, dwell_time = 16'h0002, boost_time = 16'h0002;
	reg signed [15:0] preset = 16'sh0032, pid_out = 16'sh0014, setpoint_one = 16'sh0032;
	reg signed [15:0] setpoint_two = 16'sh003c, meas_one = 16'sh0000, meas_two = 16'sh0000;
	reg signed [15:0] source_heating_out = 16'sh0000, source_cooling_out = 16'sh0000, boost_amount = 16'sh0005;
	reg signed [15:0] startup_setpoint = 16'sh0064, startup_factor = 16'sh000a;
	reg signed [15:0] feedforward_amount = 16'sh001e, scale_high_limit = 16'sh0064;
	reg signed [15:0] scale_low_limit = -16'sh0064, v, e;
	wire signed [15:0] actual, cont_output, working_setpoint, limit_reference, display_setpoint;
	wire signed [15:0] control_actual, display_actual, manip_out;
	wire [15:0] effective_cycle_time;
	wire [1:0] display_marker, startup_state;
	wire [7:0] function_word;
	wire filter_active, ramp_running, binary_contact;
	integer fails = 0, checked = 0, i;
	reg [34:0] rows [0:5];
	hrss_sequencer DUT (.ref_clk, .rst, .sample_tick(tk), .tick_per_min_unit(tk), .tick_per_sec(tk),
		.actual_raw(actual), .actual_filtered(meas_two), .meas_one, .meas_two, .source_heating_out, .source_cooling_out,
		.pid_out, .setpoint_one, .setpoint_two, .use_setpoint_two, .manual_mode, .off_state,
		.output_source, .scale_low_limit, .scale_high_limit, .ramp_rise_rate, .ramp_fall_rate,
		.suppression_period, .hot_runner_mode, .cycle_time_param, .startup_enable,
		.binary_input_function, .binary_contact, .dual_action_controller_type, .step_action_type,
		.startup_setpoint, .startup_factor, .dwell_time, .function_word_in, .function_word_wr,
		.boost_keys_held, .boost_amount, .boost_time, .feedforward_amount, .cont_output,
		.working_setpoint, .limit_reference, .display_setpoint, .display_marker, .control_actual,
		.display_actual, .filter_active, .effective_cycle_time, .manip_out, .startup_state,
		.function_word, .ramp_running);
	hrss_plant PLANT (.ref_clk, .sample_tick(tk), .load, .preset, .manip_out, .contact_req(contact),
		.actual, .binary_contact);
	// sample clock
	initial begin
		forever #25 ref_clk = ~ref_clk;
	end
	task chk(input [95:0] what, input [15:0] seen, input [15:0] exp);
		checked = checked + 1;
		if (seen !== exp) begin
			fails = fails + 1;
			$display("Error %0s expected %h seen %h", what, exp, seen);
		end
	endtask
	// n control samples, outputs settled on return
	task step(input integer n);
		repeat (n) begin
			@(posedge ref_clk);
			tk <= 1'b1;
			@(posedge ref_clk);
			tk <= 1'b0;
			repeat (2) @(posedge ref_clk);
		end
		#5;
	endtask
	task wr_word(input [7:0] w);
		@(posedge ref_clk);
		function_word_in <= w;
		function_word_wr <= 1'b1;
		@(posedge ref_clk);
		function_word_wr <= 1'b0;
	endtask
	function signed [15:0] clamp(input signed [15:0] x);
		clamp = (x < scale_low_limit) ? scale_low_limit : (x > scale_high_limit) ? scale_high_limit : x;
	endfunction
	task give_verdict;
		if (fails == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// cut a hang short far beyond the expected run
	initial begin
		repeat (4000) @(posedge ref_clk);
		fails = fails + 1;
		give_verdict;
	end
	// main sequence
	initial begin
		rows[0] = {3'h0, 16'h001e, 16'h0000};
		rows[1] = {3'h1, 16'h0000, 16'h0002};
		rows[2] = {3'h2, 16'hfed4, 16'h0003};
		rows[3] = {3'h3, 16'h0046, 16'h00fa};
		rows[4] = {3'h4, 16'h012c, 16'h00fb};
		rows[5] = {3'h5, 16'hffec, 16'h0064};
		repeat (10) @(posedge ref_clk);
		#5;
		chk("reset state", startup_state, `HRSS_ST_IDLE);
		chk("reset word", function_word, 8'h00);
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		for (i = 0; i < 6; i = i + 1) begin
			v = rows[i][31:16];
			output_source <= rows[i][34:32];
			suppression_period <= rows[i][15:0];
			preset <= v;
			meas_one <= v + 16'sh0001;
			meas_two <= v + 16'sh0002;
			source_heating_out <= v + 16'sh0003;
			source_cooling_out <= v + 16'sh0004;
			step(2);
			e = (rows[i][34:32] == `HRSS_SRC_SETPOINT) ? setpoint_one :
				(rows[i][34:32] == `HRSS_SRC_PROC) ? v : v + {13'h0000, rows[i][34:32]} - 16'sh0001;
			chk("cont out", cont_output, clamp(e));
			chk("filter", filter_active, {15'h0000, rows[i][15:0] >= `HRSS_SUPP_MIN_DS &&
				rows[i][15:0] <= `HRSS_SUPP_MAX_DS});
			chk("cycle", effective_cycle_time, cycle_time_param);
			chk("ctl actual", control_actual, (rows[i][15:0] >= `HRSS_SUPP_MIN_DS &&
				rows[i][15:0] <= `HRSS_SUPP_MAX_DS) ? v + 16'sh0002 : v);
			chk("disp actual", display_actual, v);
		end
		ramp_rise_rate <= 16'h0004;
		ramp_fall_rate <= 16'h0003;
		use_setpoint_two <= 1'b1;
		step(1);
		chk("ramp step", working_setpoint, 16'sh0036);
		chk("ramp flag", ramp_running, 16'h0001);
		chk("ramp shown", display_setpoint, setpoint_two);
		chk("ramp mark", display_marker, `HRSS_MARK_RAMP);
		chk("ramp limit", limit_reference, 16'sh0036);
		step(2);
		chk("ramp top", working_setpoint, setpoint_two);
		use_setpoint_two <= 1'b0;
		step(1);
		chk("ramp down", working_setpoint, 16'sh0039);
		step(3);
		chk("ramp end", working_setpoint, setpoint_one);
		hot_runner_mode <= 1'b1;
		dual_action_controller_type <= 1'b1;
		startup_enable <= 1'b1;
		pid_out <= 16'sh01f4;
		preset <= 16'sh0032;
		off_state <= 1'b1;
		step(1);
		chk("hot cycle", effective_cycle_time, `HRSS_HOTRUN_CYCLE_DS);
		off_state <= 1'b0;
		step(2);
		chk("startup", startup_state, `HRSS_ST_STARTUP);
		chk("clamp", manip_out, startup_factor);
		preset <= 16'sh0062;
		step(1);
		chk("hold", startup_state, `HRSS_ST_STARTUP);
		preset <= 16'sh0063;
		step(1);
		chk("dwell", startup_state, `HRSS_ST_DWELL);
		chk("dwell ref", limit_reference, startup_setpoint);
		step(4);
		chk("done", startup_state, `HRSS_ST_DONE);
		chk("valid ref", limit_reference, setpoint_one);
		wr_word(8'h08);
		step(1);
		chk("boost bit", function_word, 8'h08);
		chk("boost mark", display_marker, `HRSS_MARK_BOOST);
		chk("boost shown", display_setpoint, setpoint_one);
		step(3);
		chk("boost end", function_word, 8'h00);
		boost_time <= 16'h0009;
		boost_keys_held <= 1'b1;
		step(1);
		chk("key on", function_word, 8'h08);
		boost_keys_held <= 1'b0;
		step(1);
		boost_keys_held <= 1'b1;
		step(1);
		chk("key off", function_word, 8'h00);
		boost_keys_held <= 1'b0;
		pid_out <= 16'sh0014;
		binary_input_function <= `HRSS_BIN_FEEDFORWARD;
		contact <= 1'b1;
		step(1);
		chk("ff on", manip_out, 16'sh0032);
		contact <= 1'b0;
		step(1);
		chk("ff off", manip_out, pid_out);
		preset <= 16'sh003c;
		step(1);
		chk("no restart", startup_state, `HRSS_ST_DONE);
		preset <= 16'sh003b;
		step(1);
		chk("restart", startup_state, `HRSS_ST_STARTUP);
		give_verdict;
	end
endmodule
